// *** rtl/csr_pkg.sv ***
// package for the core special register group
// assumes one system clock domain; shared by all design files
package csr_pkg;

  // ==========================================================
  // special register space
  localparam logic [7:0] CSR_SPACE_LO      = 8'h80;
  localparam logic [7:0] CSR_STACK_PTR_ADR = 8'h81;
  localparam logic [7:0] CSR_PTR_LOW_ADR   = 8'h82;
  localparam logic [7:0] CSR_PTR_HIGH_ADR  = 8'h83;
  localparam logic [7:0] CSR_STATUS_ADR    = 8'hd0;
  localparam logic [7:0] CSR_ACC_ADR       = 8'he0;
  localparam logic [7:0] CSR_SECOND_ADR    = 8'hf0;
  localparam logic [2:0] CSR_BIT_ADR_LOW   = 3'h0;

  // ==========================================================
  // reset values
  localparam logic [7:0] CSR_STACK_RST = 8'h07;
  localparam logic [7:0] CSR_ZERO_RST  = 8'h00;

  // ==========================================================
  // status word field positions and the multiply overflow limit
  localparam int CSR_CARRY_BIT  = 7;
  localparam int CSR_NIBBLE_BIT = 6;
  localparam int CSR_USER_A_BIT = 5;
  localparam int CSR_BANK_HI    = 4;
  localparam int CSR_BANK_LO    = 3;
  localparam int CSR_OVF_BIT    = 2;
  localparam int CSR_USER_B_BIT = 1;
  localparam int CSR_PARITY_BIT = 0;
  localparam logic [7:0] CSR_MUL_MAX = 8'hff;

  // ==========================================================
  // arithmetic operations from the datapath
  typedef enum logic [3:0] {
    CSR_OP_NONE  = 4'h0,
    CSR_OP_ADD   = 4'h1,
    CSR_OP_ADD_WITH_CARRY_INSTR  = 4'h2,
    CSR_OP_SUBTRACT_BORROW_INSTR  = 4'h3,
    CSR_OP_MUL   = 4'h4,
    CSR_OP_DIV   = 4'h5,
    CSR_OP_OTHER = 4'h6
  } csr_op_e;

  typedef struct packed {
    logic       valid;
    csr_op_e    op;
    logic [7:0] operand;
  } csr_alu_req_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       bit_mode;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } csr_bus_req_s;

endpackage

// *** rtl/csr_alu.sv ***
// flag-producing arithmetic unit for the special register group
// assumes operands are stable while req is valid; purely combinational
`timescale 1ns/1ps
module csr_alu
  import csr_pkg::*;
(
  // operation
  input  wire csr_op_e    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic [7:0] second,
  input  wire logic       carry_in,
  // results
  output logic [7:0]      acc_res,
  output logic [7:0]      second_res,
  output logic            carry,
  output logic            nibble,
  output logic            ovf,
  output logic            ovf_touch,
  output logic            flag_touch
);

  logic [8:0]  sum9;
  logic [4:0]  sum5;
  logic [15:0] prod;
  logic        cin;

  always_comb begin
    cin        = (op == CSR_OP_ADD_WITH_CARRY_INSTR || op == CSR_OP_SUBTRACT_BORROW_INSTR) ? carry_in : 1'b0;
    sum9       = 9'h000;
    sum5       = 5'h00;
    prod       = 16'h0000;
    acc_res    = acc;
    second_res = second;
    carry      = 1'b0;
    nibble     = 1'b0;
    ovf        = 1'b0;
    ovf_touch  = 1'b0;
    flag_touch = 1'b1;
    case (op)
      CSR_OP_ADD, CSR_OP_ADD_WITH_CARRY_INSTR: begin
        sum9      = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
        sum5      = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        acc_res   = sum9[7:0];
        carry     = sum9[8];
        nibble    = sum5[4];
        ovf       = (acc[7] == operand[7]) && (sum9[7] != acc[7]);
        ovf_touch = 1'b1;
      end
      CSR_OP_SUBTRACT_BORROW_INSTR: begin
        sum9      = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
        sum5      = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
        acc_res   = sum9[7:0];
        carry     = sum9[8];
        nibble    = sum5[4];
        ovf       = (acc[7] != operand[7]) && (sum9[7] != acc[7]);
        ovf_touch = 1'b1;
      end
      CSR_OP_MUL: begin
        prod       = {8'h00, acc} * {8'h00, second};
        acc_res    = prod[7:0];
        second_res = prod[15:8];
        ovf        = prod > {8'h00, CSR_MUL_MAX};
        ovf_touch  = 1'b1;
      end
      CSR_OP_DIV: begin
        ovf       = (second == CSR_ZERO_RST);
        ovf_touch = 1'b1;
        if (second != CSR_ZERO_RST) begin
          acc_res    = acc / second;
          second_res = acc % second;
        end
      end
      CSR_OP_OTHER: begin
        acc_res = operand;
      end
      default: begin
        flag_touch = 1'b0;
      end
    endcase
  end

endmodule // csr_alu

// *** rtl/csr_core_regs.sv ***
// core special register group: pointers, status word, accumulator, second register
// assumes the datapath drives bus and arithmetic requests on ref_clk, never both
// to one register in the same cycle; if it does, arithmetic wins on the accumulator, second register and the status flags it touches
`timescale 1ns/1ps
module csr_core_regs
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  // special register bus
  input  wire csr_bus_req_s bus_req,
  output logic [7:0]        bus_rdata,
  output logic              bus_hit,
  // arithmetic requests
  input  wire csr_alu_req_s alu_req,
  // stack requests
  input  wire logic         push_req,
  input  wire logic [7:0]   push_data,
  input  wire logic         pop_req,
  output logic [7:0]        stack_wr_addr,
  output logic [7:0]        stack_wr_data,
  output logic              stack_wr_en,
  // register views
  output logic [15:0]       indirect_pointer_16,
  output logic [4:0]        bank_base,
  output logic [7:0]        acc_out,
  output logic [7:0]        second_out,
  output logic              carry_flag
);

  // ==========================================================
  // state
  logic [7:0] stack_top_pointer_r;
  logic [7:0] pointer_low_byte_r;
  logic [7:0] pointer_high_byte_r;
  logic [7:0] status_r;
  logic [7:0] accumulator_r;
  logic [7:0] second_r;
  logic       parity;
  logic [7:0] status_view;

  // ==========================================================
  // bus decode
  logic       in_space;
  logic       bit_ok;
  logic       wr;
  logic       hit_sp;
  logic       hit_lo;
  logic       hit_hi;
  logic       hit_st;
  logic       hit_ac;
  logic       hit_b;

  assign in_space = bus_req.valid && (bus_req.addr >= CSR_SPACE_LO);
  // bit access only on registers whose address ends in 0 or 8
  assign bit_ok   = !bus_req.bit_mode || (bus_req.addr[2:0] == CSR_BIT_ADR_LOW);
  assign wr       = in_space && bus_req.write && bit_ok;
  assign hit_sp   = bus_req.addr == CSR_STACK_PTR_ADR;
  assign hit_lo   = bus_req.addr == CSR_PTR_LOW_ADR;
  assign hit_hi   = bus_req.addr == CSR_PTR_HIGH_ADR;
  assign hit_st   = bus_req.addr == CSR_STATUS_ADR;
  assign hit_ac   = bus_req.addr == CSR_ACC_ADR;
  assign hit_b    = bus_req.addr == CSR_SECOND_ADR;

  // byte write or single-bit merge into the old value
  function automatic logic [7:0] merge(input logic [7:0] old_v);
    logic [7:0] v;
    v = old_v;
    if (bus_req.bit_mode) begin
      v[bus_req.bit_sel] = bus_req.wdata[0];
    end else begin
      v = bus_req.wdata;
    end
    return v;
  endfunction

  // ==========================================================
  // arithmetic unit
  logic [7:0] acc_res;
  logic [7:0] second_res;
  logic       alu_carry;
  logic       alu_nibble;
  logic       alu_ovf;
  logic       ovf_touch;
  logic       flag_touch;
  logic       alu_go;

  assign alu_go = alu_req.valid;

  csr_alu u_alu (
    .op         (alu_req.op),
    .acc        (accumulator_r),
    .operand    (alu_req.operand),
    .second     (second_r),
    .carry_in   (status_r[CSR_CARRY_BIT]),
    .acc_res    (acc_res),
    .second_res (second_res),
    .carry      (alu_carry),
    .nibble     (alu_nibble),
    .ovf        (alu_ovf),
    .ovf_touch  (ovf_touch),
    .flag_touch (flag_touch)
  );

  // ==========================================================
  // stack pointer
  logic [7:0] sp_inc;
  assign sp_inc = stack_top_pointer_r + 8'h01;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stack_top_pointer_r <= CSR_STACK_RST;
    end else if (clk_en) begin
      if (push_req) begin
        stack_top_pointer_r <= sp_inc;
      end else if (pop_req) begin
        stack_top_pointer_r <= stack_top_pointer_r - 8'h01;
      end else if (wr && hit_sp) begin
        stack_top_pointer_r <= merge(stack_top_pointer_r);
      end
    end
  end

  // the push write goes to the incremented location in the same cycle
  // as the increment, so the old top is never overwritten
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stack_wr_en   <= 1'b0;
      stack_wr_addr <= CSR_ZERO_RST;
      stack_wr_data <= CSR_ZERO_RST;
    end else if (clk_en) begin
      stack_wr_en   <= push_req;
      if (push_req) begin
        stack_wr_addr <= sp_inc;
        stack_wr_data <= push_data;
      end
    end
  end

  // ==========================================================
  // data pointer bytes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pointer_low_byte_r  <= CSR_ZERO_RST;
      pointer_high_byte_r <= CSR_ZERO_RST;
    end else if (clk_en) begin
      if (wr && hit_lo) begin
        pointer_low_byte_r <= merge(pointer_low_byte_r);
      end
      if (wr && hit_hi) begin
        pointer_high_byte_r <= merge(pointer_high_byte_r);
      end
    end
  end

  assign indirect_pointer_16 = {pointer_high_byte_r, pointer_low_byte_r};

  // ==========================================================
  // accumulator and second register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      accumulator_r <= CSR_ZERO_RST;
      second_r      <= CSR_ZERO_RST;
    end else if (clk_en) begin
      if (alu_go) begin
        accumulator_r <= acc_res;
        second_r      <= second_res;
      end else begin
        if (wr && hit_ac) begin
          accumulator_r <= merge(accumulator_r);
        end
        if (wr && hit_b) begin
          second_r <= merge(second_r);
        end
      end
    end
  end

  // ==========================================================
  // status word
  logic [7:0] st_nxt;

  always_comb begin
    st_nxt = status_r;
    if (wr && hit_st) begin
      st_nxt = merge(status_r);
    end
    if (alu_go && flag_touch) begin
      st_nxt[CSR_CARRY_BIT]  = alu_carry;
      st_nxt[CSR_NIBBLE_BIT] = alu_nibble;
    end
    if (alu_go && ovf_touch) begin
      st_nxt[CSR_OVF_BIT] = alu_ovf;
    end
    // stored parity bit kept at zero, the view substitutes the live value
    st_nxt[CSR_PARITY_BIT] = 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_r <= CSR_ZERO_RST;
    end else if (clk_en) begin
      status_r <= st_nxt;
    end
  end

  assign parity = ^accumulator_r;

  always_comb begin
    status_view                 = status_r;
    status_view[CSR_PARITY_BIT] = parity;
  end

  // bank base = bank number times eight
  assign bank_base = {status_r[CSR_BANK_HI:CSR_BANK_LO], 3'h0};

  // ==========================================================
  // read data, registered
  logic [7:0] rd_byte;
  logic       rd_hit;

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = CSR_ZERO_RST;
    case (bus_req.addr)
      CSR_STACK_PTR_ADR: rd_byte = stack_top_pointer_r;
      CSR_PTR_LOW_ADR:   rd_byte = pointer_low_byte_r;
      CSR_PTR_HIGH_ADR:  rd_byte = pointer_high_byte_r;
      CSR_STATUS_ADR:    rd_byte = status_view;
      CSR_ACC_ADR:       rd_byte = accumulator_r;
      CSR_SECOND_ADR:    rd_byte = second_r;
      default:           rd_hit  = 1'b0;
    endcase
    if (bus_req.bit_mode) begin
      rd_byte = {7'h00, rd_byte[bus_req.bit_sel]};
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= CSR_ZERO_RST;
      bus_hit   <= 1'b0;
    end else if (clk_en) begin
      bus_hit <= in_space && bit_ok && rd_hit;
      if (in_space && !bus_req.write && bit_ok) begin
        bus_rdata <= rd_hit ? rd_byte : CSR_ZERO_RST;
      end
    end
  end

  assign acc_out    = accumulator_r;
  assign second_out = second_r;
  assign carry_flag = status_r[CSR_CARRY_BIT];

endmodule // csr_core_regs

// *** tb/csr_core_regs_props.sv ***
// checker for the core special register group
// assumes it is bound to csr_core_regs and sees only its ports
`timescale 1ns/1ps
module csr_core_regs_props
  import csr_pkg::*;
(
  // clock and reset
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         clk_en,
  // requests
  input wire csr_bus_req_s bus_req,
  input wire csr_alu_req_s alu_req,
  input wire logic         push_req,
  input wire logic [7:0]   push_data,
  // answers
  input wire logic [7:0]   bus_rdata,
  input wire logic         bus_hit,
  input wire logic [7:0]   stack_wr_addr,
  input wire logic [7:0]   stack_wr_data,
  input wire logic         stack_wr_en,
  input wire logic [15:0]  indirect_pointer_16,
  input wire logic [4:0]   bank_base,
  input wire logic [7:0]   acc_out,
  input wire logic         carry_flag
);
  // ==========================================================
  // helpers: only quiet cycles, so a collision never muddies a check
  logic [8:0] sum9;
  logic       bwr;
  logic       brd;
  logic       add_go;
  assign sum9   = {1'b0, acc_out} + {1'b0, alu_req.operand};
  assign bwr    = clk_en && bus_req.valid && bus_req.write && !bus_req.bit_mode
                  && !alu_req.valid;
  assign brd    = clk_en && bus_req.valid && !bus_req.write && !bus_req.bit_mode
                  && !alu_req.valid;
  assign add_go = clk_en && alu_req.valid && alu_req.op == CSR_OP_ADD && !bus_req.valid;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // assertions
  a_push_write: assert property (
    clk_en && push_req |=> stack_wr_en && stack_wr_data == $past(push_data))
    else $error("push value not written");
  a_push_step: assert property (
    clk_en && push_req && stack_wr_en && !bus_req.valid
    |=> stack_wr_addr == $past(stack_wr_addr) + 8'h01)
    else $error("push address not advanced");
  a_ptr_low: assert property (
    bwr && bus_req.addr == CSR_PTR_LOW_ADR |=> indirect_pointer_16[7:0] == $past(bus_req.wdata))
    else $error("pointer low byte wrong");
  a_ptr_high: assert property (
    bwr && bus_req.addr == CSR_PTR_HIGH_ADR |=> indirect_pointer_16[15:8] == $past(bus_req.wdata))
    else $error("pointer high byte wrong");
  a_bank_map: assert property (
    bwr && bus_req.addr == CSR_STATUS_ADR |=> bank_base == {$past(bus_req.wdata[4:3]), 3'b000})
    else $error("bank base wrong");
  a_low_refused: assert property (
    clk_en && bus_req.valid && bus_req.addr < CSR_SPACE_LO |=> !bus_hit)
    else $error("low address answered");
  a_bit_refused: assert property (
    clk_en && bus_req.valid && bus_req.bit_mode && bus_req.addr[2:0] != CSR_BIT_ADR_LOW |=> !bus_hit)
    else $error("bit access answered off x0/x8");
  a_space_hit: assert property (
    brd && bus_req.addr == CSR_STACK_PTR_ADR |=> bus_hit)
    else $error("mapped read not answered");
  a_parity_read: assert property (
    brd && bus_req.addr == CSR_STATUS_ADR |=> bus_rdata[0] == ^$past(acc_out))
    else $error("parity bit wrong");
  a_add_carry: assert property (
    add_go |=> carry_flag == $past(sum9[8]) && acc_out == $past(sum9[7:0]))
    else $error("add result or carry wrong");
  c_add: cover property (add_go);
  c_push_pair: cover property (clk_en && push_req ##1 clk_en && push_req);
  c_status_read: cover property (brd && bus_req.addr == CSR_STATUS_ADR);
endmodule // csr_core_regs_props

bind csr_core_regs csr_core_regs_props csr_core_regs_props_inst (
  .ref_clk, .rst, .clk_en, .bus_req, .alu_req, .push_req, .push_data, .bus_rdata,
  .bus_hit, .stack_wr_addr, .stack_wr_data, .stack_wr_en, .indirect_pointer_16,
  .bank_base, .acc_out, .carry_flag);

// *** tb/csr_stack_mem.sv ***
// stack memory on the far side of the push path
// assumes single-cycle registered write strobes from the core
`timescale 1ns/1ps
module csr_stack_mem (
  // clock
  input wire logic       ref_clk,
  // write side
  input wire logic       stack_wr_en,
  input wire logic [7:0] stack_wr_addr,
  input wire logic [7:0] stack_wr_data,
  // bench look-up
  input wire logic [7:0] peek_addr,
  output logic [7:0]     peek_data
);
  // ==========================================================
  // storage: unwritten cells hold the inverted address, never a plausible value
  logic [7:0] mem [256];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = ~8'(i);
    end
  end
  always @(posedge ref_clk) begin
    if (stack_wr_en) begin
      mem[stack_wr_addr] <= stack_wr_data;
    end
  end
  assign peek_data = mem[peek_addr];
endmodule // csr_stack_mem

// *** tb/tb.sv ***
// self-checking bench for the core special register group
// assumes the stack memory model and the bound checker are compiled with it
`timescale 1ns/1ps
module tb;
  import csr_pkg::*;
  typedef struct {csr_op_e op; logic [7:0] pre, a, b, v, ea, eb, ep;} csr_case_s;
  // ==========================================================
  // signals
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  csr_bus_req_s bus_req = '0;
  csr_alu_req_s alu_req = '0;
  logic         push_req = 1'b0;
  logic         pop_req = 1'b0;
  logic [7:0]   push_data = 8'h00;
  logic [7:0]   peek_addr = 8'h00;
  logic [7:0]   bus_rdata, stack_wr_addr, stack_wr_data, acc_out, second_out, peek_data;
  logic         bus_hit, stack_wr_en, carry_flag;
  logic [15:0]  indirect_pointer_16;
  logic [4:0]   bank_base;
  int           n_fail = 0;
  int           n_compared = 0;
  logic [7:0]   regs [6] = '{CSR_STACK_PTR_ADR, CSR_PTR_LOW_ADR, CSR_PTR_HIGH_ADR,
                             CSR_STATUS_ADR, CSR_ACC_ADR, CSR_SECOND_ADR};
  // expected status holds every status bit but parity; parity is added from the expected accumulator
  csr_case_s    cases [11] = '{
    '{CSR_OP_ADD,   8'h00, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h00, 8'h44},
    '{CSR_OP_ADD,   8'h00, 8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'hc0},
    '{CSR_OP_ADD_WITH_CARRY_INSTR,  8'h98, 8'h10, 8'h00, 8'h20, 8'h31, 8'h00, 8'h18},
    '{CSR_OP_SUBTRACT_BORROW_INSTR,  8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'hc0},
    '{CSR_OP_SUBTRACT_BORROW_INSTR,  8'h00, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h44},
    '{CSR_OP_SUBTRACT_BORROW_INSTR,  8'ha2, 8'h50, 8'h00, 8'h10, 8'h3f, 8'h00, 8'h62},
    '{CSR_OP_MUL,   8'hc0, 8'h10, 8'h10, 8'h10, 8'h00, 8'h01, 8'h04},
    '{CSR_OP_MUL,   8'h04, 8'h02, 8'h03, 8'h03, 8'h06, 8'h00, 8'h00},
    '{CSR_OP_DIV,   8'hc0, 8'h07, 8'h02, 8'h02, 8'h03, 8'h01, 8'h00},
    '{CSR_OP_DIV,   8'h00, 8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04},
    '{CSR_OP_OTHER, 8'hc4, 8'h12, 8'h55, 8'h3c, 8'h3c, 8'h55, 8'h04}};
  always #2 ref_clk = ~ref_clk;
  csr_core_regs csr_core_regs_inst (.ref_clk, .rst, .clk_en, .bus_req, .bus_rdata, .bus_hit,
    .alu_req, .push_req, .push_data, .pop_req, .stack_wr_addr, .stack_wr_data, .stack_wr_en,
    .indirect_pointer_16, .bank_base, .acc_out, .second_out, .carry_flag);
  csr_stack_mem csr_stack_mem_inst (.ref_clk, .stack_wr_en, .stack_wr_addr, .stack_wr_data,
    .peek_addr, .peek_data);
  // ==========================================================
  // tasks: requests change at the falling edge, answers read at the next falling edge
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic bm, input logic [7:0] a,
                      input logic [2:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    bus_req = '{1'b1, w, bm, a, s, d};
    @(negedge ref_clk);
    bus_req.valid = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, 1'b0, a, 3'h0, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    xfer(1'b0, 1'b0, a, 3'h0, 8'h00);
    chk("hit", 16'(bus_hit), 16'(h));
    chk("rdata", 16'(bus_rdata), 16'(e));
  endtask
  task automatic alu(input csr_op_e op, input logic [7:0] v);
    @(negedge ref_clk);
    alu_req = '{1'b1, op, v};
    @(negedge ref_clk);
    alu_req.valid = 1'b0;
  endtask
  task automatic peek(input logic [7:0] a, input logic [7:0] e);
    peek_addr = a;
    #1;
    chk("stack cell", 16'(peek_data), 16'(e));
  endtask
  task automatic reset_check;
    foreach (regs[i]) rd(regs[i], (i == 0) ? CSR_STACK_RST : CSR_ZERO_RST, 1'b1);
    chk("pointer", indirect_pointer_16, 16'h0000);
    $display("test reset values done");
  endtask
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    reset_check();
    wr(CSR_PTR_LOW_ADR, 8'h34);
    wr(CSR_PTR_HIGH_ADR, 8'h12);
    chk("pointer", indirect_pointer_16, 16'h1234);
    rd(CSR_PTR_HIGH_ADR, 8'h12, 1'b1);
    wr(CSR_ACC_ADR, 8'h5a);
    wr(CSR_STATUS_ADR, 8'hff);
    rd(CSR_STATUS_ADR, 8'hfe, 1'b1);
    wr(CSR_ACC_ADR, 8'h5b);
    rd(CSR_STATUS_ADR, 8'hff, 1'b1);
    for (int b = 0; b < 4; b++) begin
      wr(CSR_STATUS_ADR, 8'(b << 3));
      chk("bank", 16'(bank_base), 16'(b * 8));
    end
    xfer(1'b1, 1'b1, CSR_STATUS_ADR, 3'h5, 8'h01);
    xfer(1'b1, 1'b1, CSR_STATUS_ADR, 3'h1, 8'h01);
    rd(CSR_STATUS_ADR, 8'h3b, 1'b1);
    xfer(1'b0, 1'b1, CSR_STATUS_ADR, 3'h1, 8'h00);
    chk("bit read", 16'(bus_rdata), 16'h0001);
    xfer(1'b1, 1'b1, CSR_STACK_PTR_ADR, 3'h1, 8'h01);
    chk("bit hit", 16'(bus_hit), 16'h0000);
    rd(CSR_STACK_PTR_ADR, 8'h07, 1'b1);
    rd(8'h7f, 8'h07, 1'b0);
    rd(8'h84, 8'h00, 1'b0);
    clk_en = 1'b0;
    wr(CSR_ACC_ADR, 8'h11);
    clk_en = 1'b1;
    rd(CSR_ACC_ADR, 8'h5b, 1'b1);
    $display("test register access done");
    foreach (cases[i]) begin
      wr(CSR_SECOND_ADR, cases[i].b);
      wr(CSR_ACC_ADR, cases[i].a);
      wr(CSR_STATUS_ADR, cases[i].pre);
      alu(cases[i].op, cases[i].v);
      chk("acc", 16'(acc_out), 16'(cases[i].ea));
      chk("second", 16'(second_out), 16'(cases[i].eb));
      chk("carry", 16'(carry_flag), 16'(cases[i].ep[7]));
      rd(CSR_STATUS_ADR, cases[i].ep | 8'(^cases[i].ea), 1'b1);
    end
    $display("test arithmetic flags done");
    wr(CSR_STACK_PTR_ADR, 8'h20);
    @(negedge ref_clk);
    push_req = 1'b1;
    push_data = 8'haa;
    @(negedge ref_clk);
    push_data = 8'hbb;
    @(negedge ref_clk);
    push_req = 1'b0;
    @(negedge ref_clk);
    peek(8'h20, 8'hdf);
    peek(8'h21, 8'haa);
    peek(8'h22, 8'hbb);
    rd(CSR_STACK_PTR_ADR, 8'h22, 1'b1);
    pop_req = 1'b1;
    @(negedge ref_clk);
    pop_req = 1'b0;
    rd(CSR_STACK_PTR_ADR, 8'h21, 1'b1);
    $display("test stack done");
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    reset_check();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end
endmodule // tb
